// *** bench/spc_analog_model.sv ***
// Purpose: Comparator and slow oscillator model.
// Assumes: Level 0 lies below every threshold and 5 above them all.
// Notes: The slow clock runs free, because the real one never stops.
`default_nettype none
module spc_analog_model (
  input wire logic clk_in,
  input wire logic [2:0] level_in,
  output logic [4:0] below_out,
  output logic slow_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div_q = 4'h0;
  // Thresholds rise as power-on, low trip, high trip, low warning, high warning.
  assign below_out = {level_in < 3'h5, level_in < 3'h4, level_in < 3'h3,
    level_in < 3'h2, level_in < 3'h1};
  always_ff @(posedge clk_in) div_q <= div_q + 4'h1;
  assign slow_out = div_q[3];
endmodule
`default_nettype wire

// *** bench/spc_checker_assertions.sv ***
// Purpose: Port checks on the system control block.
// Assumes: One clock, reset active low.
// Notes: Bound to every instance of the block.
`default_nettype none
module spc_checker (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic supply_below_por_in,
  input wire logic system_reset_out,
  input wire spc_pkg::spc_mode_type power_mode_out,
  input wire logic detector_on_out,
  input wire logic pin_pull_up_out,
  input wire logic pin_pull_down_out,
  input wire logic [1:0] bus_clock_select_out,
  input wire logic bus_tick_out,
  input wire logic fast_oscillator_enable_out,
  input wire logic medium_oscillator_enable_out,
  input wire logic slow_oscillator_enable_out
);
  import spc_pkg::*;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Any faster code ticks within eight clocks, so eight quiet ones expose it.
  // Software may move the select mid-period, and a tick under the new code is legal.
  sequence quiet_gap;
    (!bus_tick_out || bus_clock_select_out != 2'h3) [*8];
  endsequence
  chk_pin_layout: assert property (
    $past(reg_read_in) && $past(reg_addr_in) == 3'h0 |-> reg_rdata_out[7:6] == 2'h0
      && !reg_rdata_out[2]) else $error("pin register fixed bits wrong");
  chk_pull_excl: assert property (
    pin_pull_down_out |-> !pin_pull_up_out) else $error("both pulls on");
  chk_sel_clear: assert property (
    $fell(system_reset_out) |-> bus_clock_select_out == 2'h0) else $error("select kept");
  chk_slow_always: assert property (
    slow_oscillator_enable_out) else $error("slow oscillator off");
  chk_run_osc: assert property (
    power_mode_out == SPC_RUN && $past(power_mode_out) == SPC_RUN
      |-> fast_oscillator_enable_out && medium_oscillator_enable_out)
    else $error("oscillator off in run");
  chk_stop_detect: assert property (
    power_mode_out inside {SPC_STOP1, SPC_STOP2, SPC_STOP3} && $stable(power_mode_out)
      |-> !detector_on_out) else $error("detector on in deep stop");
  chk_tick_gap: assert property (
    bus_tick_out && bus_clock_select_out == 2'h3 && $past(bus_clock_select_out) == 2'h3
      |=> quiet_gap) else $error("bus tick too soon");
  chk_por_hold: assert property (
    supply_below_por_in [*6] |-> system_reset_out) else $error("no power-on hold");
endmodule
bind spc_system_control spc_checker chk (.*);
`default_nettype wire

// *** bench/spc_system_control_bench.sv ***
// Purpose: Self-checking bench for the system control block.
// Assumes: Fast tick shortened to 8 clocks.
// Notes: Rows cover plain register access; hand tests follow.
`default_nettype none
module spc_system_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;
  logic clk_in = 1'b0, reset_n_in = 1'b0, reg_write_in = 1'b0, reg_read_in = 1'b0;
  logic temp_below_restart_in = 1'b0, pin_request_in = 1'b0, stop_request_in = 1'b0;
  logic low_freq_receiver_request_in = 1'b0, wait_request_in = 1'b0, wake_request_in = 1'b0;
  logic [2:0] reg_addr_in = 3'h0, level = 3'h5;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out;
  logic [1:0] stop_depth_in = 2'h0, bus_clock_select_out;
  logic supply_below_por_in, supply_below_trip_high_in, supply_below_trip_low_in;
  logic supply_below_warn_high_in, supply_below_warn_low_in, slow_oscillator_in;
  logic system_reset_out, detector_on_out, supply_detect_irq_out, pin_request_irq_out;
  logic tick_irq_out, pin_pull_up_out, pin_pull_down_out, bus_tick_out;
  logic fast_oscillator_enable_out, medium_oscillator_enable_out, slow_oscillator_enable_out;
  spc_mode_type power_mode_out;
  int checks = 0, n_mismatch = 0, n;
  localparam logic [18:0] ROWS [10] = '{{3'h0, 8'hEF, 8'h23}, {3'h0, 8'h00, 8'h00},
    {3'h3, 8'h83, 8'h83}, {3'h3, 8'h00, 8'h00}, {3'h2, 8'h30, 8'h30}, {3'h2, 8'h00, 8'h00},
    {3'h4, 8'h77, 8'h37}, {3'h4, 8'h00, 8'h00}, {3'h6, 8'hFF, 8'h00}, {3'h1, 8'hFF, 8'h3C}};
  spc_system_control #(.FAST_TICK_CYCLES(8)) uut (.*);
  spc_analog_model model (.clk_in, .level_in(level), .slow_out(slow_oscillator_in),
    .below_out({supply_below_warn_high_in, supply_below_warn_low_in,
    supply_below_trip_high_in, supply_below_trip_low_in, supply_below_por_in}));
  task automatic chk(input string nm, input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    @(negedge clk_in);
    chk("read", reg_rdata_out, e);
  endtask
  task automatic stop(input logic [1:0] d, input spc_mode_type m);
    @(posedge clk_in);
    stop_depth_in <= d;
    stop_request_in <= 1'b1;
    @(posedge clk_in);
    stop_request_in <= 1'b0;
    cyc(3);
    chk("mode", {5'h00, power_mode_out}, {5'h00, m});
    wake_request_in <= 1'b1;
    cyc(3);
    wake_request_in <= 1'b0;
  endtask
  task automatic rel;
    for (int k = 0; k < 60 && system_reset_out !== 1'b0; k++) @(posedge clk_in);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    conclude();
  end
  initial begin
    cyc(10);
    chk("hold", {7'h00, system_reset_out}, 8'h01);
    reset_n_in <= 1'b1;
    rel();
    rc(3'h5, 8'h82);
    rc(3'h1, 8'h14);
    $display("done: reset");
    foreach (ROWS[i]) begin
      wr(ROWS[i][18:16], ROWS[i][15:8]);
      rc(ROWS[i][18:16], ROWS[i][7:0]);
    end
    $display("done: table");
    wr(3'h3, 8'h03);
    cyc(20);
    chk("select", {6'h00, bus_clock_select_out}, 8'h03);
    for (n = 0; n < 40 && !bus_tick_out; n++) @(posedge clk_in);
    @(posedge clk_in);
    for (n = 1; n < 40 && !bus_tick_out; n++) @(posedge clk_in);
    chk("tick gap", n[7:0], 8'h10);
    cyc(12);
    $display("done: clock");
    wr(3'h0, 8'h32);
    cyc(2);
    chk("pulls", {6'h00, pin_pull_up_out, pin_pull_down_out}, 8'h01);
    pin_request_in <= 1'b1;
    cyc(6);
    chk("pin irq", {7'h00, pin_request_irq_out}, 8'h01);
    rc(3'h0, 8'h3A);
    wr(3'h0, 8'h36);
    rc(3'h0, 8'h32);
    wr(3'h0, 8'h37);
    wr(3'h0, 8'h37);
    rc(3'h0, 8'h3B);
    @(posedge clk_in);
    pin_request_in <= 1'b0;
    cyc(4);
    wr(3'h0, 8'h37);
    rc(3'h0, 8'h33);
    wr(3'h0, 8'h00);
    $display("done: pin");
    wr(3'h1, 8'h24);
    level <= 3'h1;
    cyc(8);
    chk("detect irq", {7'h00, supply_detect_irq_out}, 8'h01);
    wr(3'h2, 8'h40);
    rc(3'h2, 8'h80);
    @(posedge clk_in);
    level <= 3'h5;
    cyc(6);
    wr(3'h1, 8'h64);
    wr(3'h2, 8'h40);
    rc(3'h2, 8'h00);
    chk("detect irq", {7'h00, supply_detect_irq_out}, 8'h00);
    wr(3'h3, 8'h02);
    wr(3'h1, 8'h14);
    level <= 3'h1;
    cyc(6);
    chk("hold", {7'h00, system_reset_out}, 8'h01);
    level <= 3'h5;
    rel();
    rc(3'h5, 8'h02);
    chk("select", {6'h00, bus_clock_select_out}, 8'h00);
    level <= 3'h0;
    cyc(8);
    level <= 3'h5;
    rel();
    rc(3'h5, 8'h82);
    $display("done: supply");
    wr(3'h1, 8'h1C);
    stop(2'h0, SPC_STOP4);
    wr(3'h1, 8'h04);
    stop(2'h2, SPC_STOP3);
    cyc(3);
    chk("detector", {7'h00, detector_on_out}, 8'h01);
    wait_request_in <= 1'b1;
    cyc(1);
    wait_request_in <= 1'b0;
    cyc(2);
    chk("wait osc", {5'h00, power_mode_out == SPC_WAIT, fast_oscillator_enable_out,
      medium_oscillator_enable_out}, 8'h07);
    wake_request_in <= 1'b1;
    cyc(1);
    wake_request_in <= 1'b0;
    $display("done: stop");
    wr(3'h4, 8'h11);
    for (n = 0; n < 200 && !tick_irq_out; n++) @(posedge clk_in);
    chk("tick irq", {7'h00, tick_irq_out}, 8'h01);
    rc(3'h4, 8'h91);
    wr(3'h4, 8'h50);
    cyc(100);
    rc(3'h4, 8'h10);
    $display("done: tick");
    wr(3'h3, 8'h80);
    stop(2'h1, SPC_STOP2);
    temp_below_restart_in <= 1'b1;
    cyc(5);
    chk("temp exit", {7'h00, system_reset_out}, 8'h01);
    rel();
    rc(3'h5, 8'h00);
    $display("done: temperature");
    conclude();
  end
endmodule
`default_nettype wire

// *** design/spc_defines.svh ***
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Register data is eight bits wide on a three-bit index.
// Notes: Included by the control block.
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
`define SPC_ADDR_PIN 3'h0
`define SPC_ADDR_ONE 3'h1
`define SPC_ADDR_THREE 3'h2
`define SPC_ADDR_TWO 3'h3
`define SPC_ADDR_TICK 3'h4
`define SPC_ADDR_SRC 3'h5
`define SPC_PIN_POL 5
`define SPC_PIN_EN 4
`define SPC_PIN_FLAG 3
`define SPC_PIN_ACK 2
`define SPC_PIN_IE 1
`define SPC_PIN_MOD 0
`define SPC_ONE_FLAG 7
`define SPC_ONE_ACK 6
`define SPC_ONE_IE 5
`define SPC_ONE_RE 4
`define SPC_ONE_SE 3
`define SPC_ONE_DE 2
`define SPC_THR_WFLAG 7
`define SPC_THR_WACK 6
`define SPC_THR_TRIP 5
`define SPC_THR_WSEL 4
`define SPC_TWO_TRE 7
`define SPC_TICK_FLAG 7
`define SPC_TICK_ACK 6
`define SPC_TICK_CLK 5
`define SPC_TICK_IE 4
`define SPC_SRC_POR 7
`define SPC_SRC_LOW 1
`define SPC_DE_RESET 1'b1
`define SPC_RE_RESET 1'b1
`define SPC_CLK_MHZ 250
`define SPC_FAST_TICK_US 1000
`define SPC_FAST_TICK_CYCLES (`SPC_FAST_TICK_US * `SPC_CLK_MHZ)
`define SPC_SYNC_WIDTH 9
`define SPC_IN_POR 0
`define SPC_IN_TRIPH 1
`define SPC_IN_TRIPL 2
`define SPC_IN_WARNH 3
`define SPC_IN_WARNL 4
`define SPC_IN_TEMP 5
`define SPC_IN_PIN 6
`define SPC_IN_SLOW 7
`define SPC_IN_LFR 8
`endif

// *** design/spc_pkg.sv ***
// Purpose: Types shared by the system control block.
// Assumes: Nothing beyond the defines header.
// Notes: Encodings count up from zero in declaration order.
`default_nettype none
package spc_pkg;
  typedef enum logic [2:0] {
    SPC_RUN, SPC_WAIT, SPC_STOP4, SPC_STOP3, SPC_STOP2, SPC_STOP1
  } spc_mode_type;
  typedef enum logic [1:0] {
    SPC_HOLD_NONE, SPC_HOLD_POR, SPC_HOLD_LOW, SPC_HOLD_OTHER
  } spc_hold_type;
endpackage
`default_nettype wire

// *** design/spc_system_control.sv ***
// Purpose: Supply detect, warning, clock select, tick timer, pin request.
// Assumes: Comparator, pin and slow oscillator inputs are asynchronous.
// Notes: Stop depth codes 0..3 mean deepest to shallowest stop.
// Operation
// - Detector runs only when enabled; trip select picks high or low threshold.
// - Stop entry disables detector unless stop-enable; both set forces shallowest stop.
// - Power-on holds reset until above low trip, then sets both source flags.
// - With reset-enable, low supply resets and holds until above selected trip.
// - Enabled detector with interrupt enable and without reset-enable sets its flag and raises an interrupt.
// - Warning flag sets below level; acknowledge clears only once supply recovers.
// - Warning level has two choices and never raises an interrupt.
// - Bus clock select codes give fast oscillator 8 to 1 MHz, bus half.
// - Every reset clears both bus clock select bits.
// - Medium and fast oscillators run in run and wait; receiver can add medium.
// - Slow oscillator runs in every mode; software cannot stop it.
// - Tick timer uses slow or fast source; fast source gives no stop ticks.
// - Three-bit period picks 2 to 128 ms; zero stops the timer.
// - Read-only expiry flag, write-one acknowledge, local enable, interrupt or wake.
// - Temperature wake from two deepest stops when enabled; that exit resets.
// - Pin register: top two bits zero, four control, one flag, one acknowledge.
// - Polarity bit picks falling/low or rising/high; rising flips pull to down.
// - Pin enable makes the pin a request input and turns on its pull.
// - Pin flag sets on each qualifying event of chosen polarity and type.
// - Acknowledge one clears flag, reads zero; level mode keeps flag while asserted.
// - With pin interrupt enable, a set flag requests a hardware interrupt.
// - Mode bit chooses edge-only or edge-and-level detection.
`include "spc_defines.svh"
`default_nettype none
module spc_system_control #(
  parameter int FAST_TICK_CYCLES = `SPC_FAST_TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  input wire logic supply_below_por_in,
  input wire logic supply_below_trip_high_in,
  input wire logic supply_below_trip_low_in,
  input wire logic supply_below_warn_high_in,
  input wire logic supply_below_warn_low_in,
  input wire logic temp_below_restart_in,
  input wire logic pin_request_in,
  input wire logic slow_oscillator_in,
  input wire logic low_freq_receiver_request_in,
  input wire logic wait_request_in,
  input wire logic stop_request_in,
  input wire logic [1:0] stop_depth_in,
  input wire logic wake_request_in,
  output logic system_reset_out,
  output spc_pkg::spc_mode_type power_mode_out,
  output logic detector_on_out,
  output logic supply_detect_irq_out,
  output logic pin_request_irq_out,
  output logic tick_irq_out,
  output logic pin_pull_up_out,
  output logic pin_pull_down_out,
  output logic [1:0] bus_clock_select_out,
  output logic bus_tick_out,
  output logic fast_oscillator_enable_out,
  output logic medium_oscillator_enable_out,
  output logic slow_oscillator_enable_out
);
  import spc_pkg::*;

  localparam int FTW = $clog2(FAST_TICK_CYCLES + 1);

  logic [`SPC_SYNC_WIDTH-1:0] sync1_q;
  logic [`SPC_SYNC_WIDTH-1:0] sync2_q;
  spc_mode_type mode_q;
  spc_hold_type hold_q;
  logic in_hold;
  logic in_stop;
  logic in_deep;
  logic wr;
  // Pin register fields.
  logic pin_pol_q;
  logic pin_en_q;
  logic pin_flag_q;
  logic pin_ie_q;
  logic pin_mod_q;
  logic pin_prev_q;
  // Supply control fields.
  logic det_en_q;
  logic det_ie_q;
  logic det_re_q;
  logic det_se_q;
  logic det_flag_q;
  logic trip_sel_q;
  logic warn_sel_q;
  logic warn_flag_q;
  logic por_flag_q;
  logic low_flag_q;
  // Options and tick fields.
  logic temp_en_q;
  logic [1:0] bus_sel_q;
  logic tick_clk_q;
  logic tick_ie_q;
  logic [2:0] tick_per_q;
  logic tick_flag_q;
  logic slow_prev_q;
  logic [FTW-1:0] fast_cnt_q;
  logic [6:0] tick_cnt_q;
  logic [3:0] bus_cnt_q;

  // Bit order of this vector follows the input index defines.
  logic [`SPC_SYNC_WIDTH-1:0] sync_raw;
  assign sync_raw = {low_freq_receiver_request_in, slow_oscillator_in, pin_request_in,
                     temp_below_restart_in, supply_below_warn_low_in, supply_below_warn_high_in,
                     supply_below_trip_low_in, supply_below_trip_high_in, supply_below_por_in};

  generate
    for (genvar i = 0; i < `SPC_SYNC_WIDTH; i++) begin : g_sync
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          sync1_q[i] <= 1'b0;
          sync2_q[i] <= 1'b0;
        end else begin
          sync1_q[i] <= sync_raw[i];
          sync2_q[i] <= sync1_q[i];
        end
      end
    end
  endgenerate

  assign in_hold = (hold_q != SPC_HOLD_NONE);
  assign in_stop = (mode_q != SPC_RUN) && (mode_q != SPC_WAIT);
  assign in_deep = (mode_q == SPC_STOP1) || (mode_q == SPC_STOP2);
  assign wr = reg_write_in && !in_hold;

  logic det_active;
  logic below_trip;
  logic below_warn;
  assign det_active = det_en_q && !(in_stop && !det_se_q);
  assign below_trip = trip_sel_q ? sync2_q[`SPC_IN_TRIPH] : sync2_q[`SPC_IN_TRIPL];
  assign below_warn = warn_sel_q ? sync2_q[`SPC_IN_WARNH] : sync2_q[`SPC_IN_WARNL];

  logic pin_asserted;
  logic pin_event;
  assign pin_asserted = pin_pol_q ? sync2_q[`SPC_IN_PIN] : !sync2_q[`SPC_IN_PIN];
  assign pin_event = pin_en_q && ((pin_asserted && !pin_prev_q) ||
                                  (pin_mod_q && pin_asserted));

  logic slow_tick;
  logic fast_tick;
  logic tick_src;
  logic tick_expire;
  logic [6:0] tick_last;
  assign slow_tick = sync2_q[`SPC_IN_SLOW] && !slow_prev_q;
  assign fast_tick = (fast_cnt_q == FTW'(FAST_TICK_CYCLES - 1)) && !in_stop;
  assign tick_src = tick_clk_q ? fast_tick : slow_tick;
  // period of 2 to 128 ticks of the selected source
  assign tick_last = 7'((8'h01 << tick_per_q) - 8'h01);
  assign tick_expire = (tick_per_q != 3'h0) && tick_src && (tick_cnt_q == tick_last);

  logic tick_wake;
  logic temp_wake;
  logic deep_exit;
  logic shallow_wake;
  assign tick_wake = tick_flag_q && tick_ie_q;
  assign temp_wake = temp_en_q && in_deep && sync2_q[`SPC_IN_TEMP];
  assign deep_exit = in_deep && (temp_wake || tick_wake || (pin_flag_q && pin_ie_q));
  assign shallow_wake = tick_wake || (pin_flag_q && pin_ie_q) ||
                        (det_flag_q && det_ie_q) || wake_request_in;

  // Reset hold sequencing; power-on outranks everything else.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_q <= SPC_HOLD_POR;
    end else if (sync2_q[`SPC_IN_POR]) begin
      hold_q <= SPC_HOLD_POR;
    end else begin
      unique case (hold_q)
        SPC_HOLD_POR: if (!sync2_q[`SPC_IN_TRIPL]) hold_q <= SPC_HOLD_NONE;
        SPC_HOLD_LOW: if (!below_trip) hold_q <= SPC_HOLD_NONE;
        SPC_HOLD_OTHER: hold_q <= SPC_HOLD_NONE;
        SPC_HOLD_NONE: begin
          if (det_active && det_re_q && below_trip) begin
            hold_q <= SPC_HOLD_LOW;
          end else if (deep_exit) begin
            hold_q <= SPC_HOLD_OTHER;
          end
        end
      endcase
    end
  end

  // Reset source flags are written when the hold ends.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      por_flag_q <= 1'b0;
      low_flag_q <= 1'b0;
    end else if (in_hold && !sync2_q[`SPC_IN_POR]) begin
      if (hold_q == SPC_HOLD_POR && !sync2_q[`SPC_IN_TRIPL]) begin
        por_flag_q <= 1'b1;
        low_flag_q <= 1'b1;
      end else if (hold_q == SPC_HOLD_LOW && !below_trip) begin
        por_flag_q <= 1'b0;
        low_flag_q <= 1'b1;
      end else if (hold_q == SPC_HOLD_OTHER) begin
        por_flag_q <= 1'b0;
        low_flag_q <= 1'b0;
      end
    end
  end

  // Power mode sequencing.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q <= SPC_RUN;
    end else if (in_hold) begin
      mode_q <= SPC_RUN;
    end else begin
      unique case (mode_q)
        SPC_RUN: begin
          if (stop_request_in) begin
            if (det_se_q && det_en_q) begin
              mode_q <= SPC_STOP4;
            end else begin
              unique case (stop_depth_in)
                2'h0: mode_q <= SPC_STOP1;
                2'h1: mode_q <= SPC_STOP2;
                2'h2: mode_q <= SPC_STOP3;
                2'h3: mode_q <= SPC_STOP4;
              endcase
            end
          end else if (wait_request_in) begin
            mode_q <= SPC_WAIT;
          end
        end
        SPC_WAIT, SPC_STOP3, SPC_STOP4: if (shallow_wake) mode_q <= SPC_RUN;
        SPC_STOP2, SPC_STOP1: if (deep_exit) mode_q <= SPC_RUN;
      endcase
    end
  end

  // Supply control fields; trip select survives low-supply resets so release can use it.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      det_en_q <= `SPC_DE_RESET;
      det_re_q <= `SPC_RE_RESET;
      det_ie_q <= 1'b0;
      det_se_q <= 1'b0;
      warn_sel_q <= 1'b0;
    end else if (in_hold) begin
      det_en_q <= `SPC_DE_RESET;
      det_re_q <= `SPC_RE_RESET;
      det_ie_q <= 1'b0;
      det_se_q <= 1'b0;
      warn_sel_q <= 1'b0;
    end else if (wr && reg_addr_in == `SPC_ADDR_ONE) begin
      det_en_q <= reg_wdata_in[`SPC_ONE_DE];
      det_re_q <= reg_wdata_in[`SPC_ONE_RE];
      det_ie_q <= reg_wdata_in[`SPC_ONE_IE];
      det_se_q <= reg_wdata_in[`SPC_ONE_SE];
    end else if (wr && reg_addr_in == `SPC_ADDR_THREE) begin
      warn_sel_q <= reg_wdata_in[`SPC_THR_WSEL];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trip_sel_q <= 1'b0;
    end else if (hold_q == SPC_HOLD_POR) begin
      trip_sel_q <= 1'b0;
    end else if (wr && reg_addr_in == `SPC_ADDR_THREE) begin
      trip_sel_q <= reg_wdata_in[`SPC_THR_TRIP];
    end
  end

  // detect flag, set wins over acknowledge
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      det_flag_q <= 1'b0;
    end else if (det_active && det_ie_q && !det_re_q && below_trip) begin
      det_flag_q <= 1'b1;
    end else if (in_hold || (wr && reg_addr_in == `SPC_ADDR_ONE &&
                             reg_wdata_in[`SPC_ONE_ACK])) begin
      det_flag_q <= 1'b0;
    end
  end

  // warning flag clears only once supply recovers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      warn_flag_q <= 1'b0;
    end else if (below_warn) begin
      warn_flag_q <= 1'b1;
    end else if (wr && reg_addr_in == `SPC_ADDR_THREE && reg_wdata_in[`SPC_THR_WACK]) begin
      warn_flag_q <= 1'b0;
    end
  end

  // Options: clears the clock select on every reset.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_sel_q <= 2'h0;
      temp_en_q <= 1'b0;
    end else if (in_hold) begin
      bus_sel_q <= 2'h0;
      temp_en_q <= 1'b0;
    end else if (wr && reg_addr_in == `SPC_ADDR_TWO) begin
      bus_sel_q <= reg_wdata_in[1:0];
      temp_en_q <= reg_wdata_in[`SPC_TWO_TRE];
    end
  end

  // bus tick every 2, 4, 8 or 16 fast oscillator periods at full rate
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_cnt_q <= 4'h0;
      bus_tick_out <= 1'b0;
    end else if (bus_cnt_q >= 4'((5'h02 << bus_sel_q) - 5'h01)) begin
      bus_cnt_q <= 4'h0;
      bus_tick_out <= 1'b1;
    end else begin
      bus_cnt_q <= bus_cnt_q + 4'h1;
      bus_tick_out <= 1'b0;
    end
  end

  // Pin register fields.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_pol_q <= 1'b0;
      pin_en_q <= 1'b0;
      pin_ie_q <= 1'b0;
      pin_mod_q <= 1'b0;
    end else if (in_hold) begin
      pin_pol_q <= 1'b0;
      pin_en_q <= 1'b0;
      pin_ie_q <= 1'b0;
      pin_mod_q <= 1'b0;
    end else if (wr && reg_addr_in == `SPC_ADDR_PIN) begin
      pin_pol_q <= reg_wdata_in[`SPC_PIN_POL];
      pin_en_q <= reg_wdata_in[`SPC_PIN_EN];
      pin_ie_q <= reg_wdata_in[`SPC_PIN_IE];
      pin_mod_q <= reg_wdata_in[`SPC_PIN_MOD];
    end
  end

  // A fresh enable would otherwise see a stale level as an edge.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_prev_q <= 1'b1;
    end else begin
      pin_prev_q <= pin_asserted || !pin_en_q;
    end
  end

  // acknowledge loses to an asserted level in level mode
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_flag_q <= 1'b0;
    end else if (pin_event && !in_hold) begin
      pin_flag_q <= 1'b1;
    end else if (in_hold || (wr && reg_addr_in == `SPC_ADDR_PIN &&
                             reg_wdata_in[`SPC_PIN_ACK])) begin
      pin_flag_q <= 1'b0;
    end
  end

  // Tick timer control fields.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_clk_q <= 1'b0;
      tick_ie_q <= 1'b0;
      tick_per_q <= 3'h0;
    end else if (in_hold) begin
      tick_clk_q <= 1'b0;
      tick_ie_q <= 1'b0;
      tick_per_q <= 3'h0;
    end else if (wr && reg_addr_in == `SPC_ADDR_TICK) begin
      tick_clk_q <= reg_wdata_in[`SPC_TICK_CLK];
      tick_ie_q <= reg_wdata_in[`SPC_TICK_IE];
      tick_per_q <= reg_wdata_in[2:0];
    end
  end

  // fast source prescaler held in stop
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fast_cnt_q <= '0;
      slow_prev_q <= 1'b0;
    end else begin
      slow_prev_q <= sync2_q[`SPC_IN_SLOW];
      if (in_stop || fast_cnt_q == FTW'(FAST_TICK_CYCLES - 1)) begin
        fast_cnt_q <= '0;
      end else begin
        fast_cnt_q <= fast_cnt_q + FTW'(1);
      end
    end
  end

  // period counter, idle at code zero
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_cnt_q <= 7'h00;
    end else if (in_hold || tick_per_q == 3'h0 || tick_expire) begin
      tick_cnt_q <= 7'h00;
    end else if (tick_src) begin
      tick_cnt_q <= tick_cnt_q + 7'h01;
    end
  end

  // expiry flag, set wins over acknowledge
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_flag_q <= 1'b0;
    end else if (tick_expire && !in_hold) begin
      tick_flag_q <= 1'b1;
    end else if (in_hold || (wr && reg_addr_in == `SPC_ADDR_TICK &&
                             reg_wdata_in[`SPC_TICK_ACK])) begin
      tick_flag_q <= 1'b0;
    end
  end

  // Registered outputs.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      system_reset_out <= 1'b1;
      power_mode_out <= SPC_RUN;
      detector_on_out <= 1'b0;
      supply_detect_irq_out <= 1'b0;
      pin_request_irq_out <= 1'b0;
      tick_irq_out <= 1'b0;
      pin_pull_up_out <= 1'b0;
      pin_pull_down_out <= 1'b0;
      bus_clock_select_out <= 2'h0;
      fast_oscillator_enable_out <= 1'b1;
      medium_oscillator_enable_out <= 1'b1;
      slow_oscillator_enable_out <= 1'b1;
    end else begin
      system_reset_out <= in_hold;
      power_mode_out <= mode_q;
      detector_on_out <= det_active;
      supply_detect_irq_out <= det_flag_q && det_ie_q;
      pin_request_irq_out <= pin_flag_q && pin_ie_q;
      tick_irq_out <= tick_flag_q && tick_ie_q;
      pin_pull_up_out <= pin_en_q && !pin_pol_q;
      pin_pull_down_out <= pin_en_q && pin_pol_q;
      bus_clock_select_out <= bus_sel_q;
      fast_oscillator_enable_out <= !in_stop;
      medium_oscillator_enable_out <= !in_stop || sync2_q[`SPC_IN_LFR];
      slow_oscillator_enable_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (!reg_read_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      unique case (reg_addr_in)
        `SPC_ADDR_PIN: reg_rdata_out <= {2'h0, pin_pol_q, pin_en_q, pin_flag_q, 1'b0,
                                         pin_ie_q, pin_mod_q};
        `SPC_ADDR_ONE: reg_rdata_out <= {det_flag_q, 1'b0, det_ie_q, det_re_q, det_se_q,
                                         det_en_q, 2'h0};
        `SPC_ADDR_THREE: reg_rdata_out <= {warn_flag_q, 1'b0, trip_sel_q, warn_sel_q, 4'h0};
        `SPC_ADDR_TWO: reg_rdata_out <= {temp_en_q, 5'h00, bus_sel_q};
        `SPC_ADDR_TICK: reg_rdata_out <= {tick_flag_q, 1'b0, tick_clk_q, tick_ie_q, 1'b0,
                                          tick_per_q};
        `SPC_ADDR_SRC: reg_rdata_out <= {por_flag_q, 5'h00, low_flag_q, 1'b0};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire
